// File: crsi_pkg.sv
// constants, register map and state record for the core reset state block
// assumes one 50 MHz clock and an axi4-lite master reaching the registers

package crsi_pkg;

   // ************************************************************
   // register byte offsets
   // ************************************************************
   localparam logic [7:0] OFF_DBG_ST   = 8'h00;
   localparam logic [7:0] OFF_SYNDROME = 8'h04;
   localparam logic [7:0] OFF_MCHK_ST  = 8'h08;
   localparam logic [7:0] OFF_MSTATE   = 8'h0c;
   localparam logic [7:0] OFF_VERSION  = 8'h10;
   localparam logic [7:0] OFF_PC     = 8'h14;
   localparam logic [7:0] OFF_IRQ_ST = 8'h18;
   localparam logic [7:0] OFF_IRQ_MK = 8'h1c;

   // ************************************************************
   // field layout
   // ************************************************************
   // debug flags sit in bits 14:0, in the order of the event input vector
   localparam int          DBG_FLAGS   = 15;
   localparam int          RTYPE_LSB      = 28;
   localparam int          SYNC_MCHK_BIT  = 27;
   localparam int          ASYNC_MCHK_BIT = 31;
   localparam int          OWNER_LSB   = 20;
   localparam logic [31:0] DBG_ST_W1C  = 32'h3000_7fff;
   localparam logic [31:0] MCHK_ST_W1C = 32'h8000_0000;
   // writable bits: enables, problem state, float, debug and address space controls
   localparam logic [31:0] MSTATE_WMASK = 32'h0006_ff30;
   localparam logic [31:0] PC_WMASK    = 32'hffff_fffc;

   // ************************************************************
   // reset values and encodings
   // ************************************************************
   localparam logic [31:0] PC_RESET    = 32'hffff_fffc;
   localparam logic [31:0] MSTATE_RESET = 32'h0000_0000;
   localparam logic [1:0]  RTYPE_NONE   = 2'h0;
   localparam logic [1:0]  RTYPE_CORE   = 2'h1;
   localparam logic [1:0]  RTYPE_CHIP   = 2'h2;
   localparam logic [1:0]  RTYPE_SYSTEM = 2'h3;
   localparam logic [1:0]  RESP_OKAY   = 2'h0;
   localparam logic [1:0]  RESP_SLVERR = 2'h2;

   // whole state of the block, registered once per clock
   typedef struct packed {
      logic [31:0] dbg_st;
      logic [31:0] syndrome;
      logic [31:0] mchk_st;
      logic [31:0] mstate;
      logic [31:0] pc;
      logic [1:0]  irq_st;
      logic [1:0]  irq_mk;
      logic        irq;
      logic        awready;
      logic        wready;
      logic        bvalid;
      logic [1:0]  bresp;
      logic        arready;
      logic        rvalid;
      logic [31:0] rdata;
      logic [1:0]  rresp;
   } crsi_state_s;

   // reset sources presented by system logic
   typedef struct packed {
      logic core;
      logic chip;
      logic system;
   } crsi_rst_src_s;

   localparam crsi_state_s ST_RESET = '{pc: PC_RESET, mstate: MSTATE_RESET, default: '0};

endpackage : crsi_pkg

// File: crsi_top.sv
// register bank holding the reset state of the core status and control registers
// assumes synchronous inputs, an axi4-lite master and one clock clk_sys
//
// Design decisions made here: the AXI4-Lite interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none

module crsi_top #(
   parameter int OWNER_W = 12
) (
   input  wire logic                   clk_sys,
   input  wire logic                   srst,
   input  wire crsi_pkg::crsi_rst_src_s rst_src,
   input  wire logic [14:0]            dbg_evt,
   input  wire logic                   sync_mcheck,
   input  wire logic                   async_mcheck,
   input  wire logic [OWNER_W-1:0]     owner_field,
   input  wire logic [31-OWNER_W:0]    version_number_field,
   input  wire logic [7:0]             s_axi_awaddr,
   input  wire logic                   s_axi_awvalid,
   output logic                        s_axi_awready,
   input  wire logic [31:0]            s_axi_wdata,
   input  wire logic [3:0]             s_axi_wstrb,
   input  wire logic                   s_axi_wvalid,
   output logic                        s_axi_wready,
   output logic [1:0]                  s_axi_bresp,
   output logic                        s_axi_bvalid,
   input  wire logic                   s_axi_bready,
   input  wire logic [7:0]             s_axi_araddr,
   input  wire logic                   s_axi_arvalid,
   output logic                        s_axi_arready,
   output logic [31:0]                 s_axi_rdata,
   output logic [1:0]                  s_axi_rresp,
   output logic                        s_axi_rvalid,
   input  wire logic                   s_axi_rready,
   output logic [31:0]                 machine_state,
   output logic [31:0]                 program_counter,
   output logic                        irq
);

   // ************************************************************
   // state and decode
   // ************************************************************
   crsi_pkg::crsi_state_s st_q;
   crsi_pkg::crsi_state_s st_d;
   logic                  any_rst;
   logic [1:0]            rst_kind;
   logic                  wr_go;
   logic                  rd_go;
   logic [31:0]           wmask;
   logic [31:0]           wbits;
   logic [31:0]           rd_val;
   logic                  rd_hit;
   logic                  wr_hit;

   // ************************************************************
   // reset sources
   // ************************************************************
   // any source holds the reset values for as long as it stands
   assign any_rst  = rst_src.core | rst_src.chip | rst_src.system;

   // reset kind, highest scope wins when several sources overlap
   // distinct reset sources
   always_comb
   begin
      if (rst_src.system)
      begin
         rst_kind = crsi_pkg::RTYPE_SYSTEM;
      end
      else if (rst_src.chip)
      begin
         rst_kind = crsi_pkg::RTYPE_CHIP;
      end
      else if (rst_src.core)
      begin
         rst_kind = crsi_pkg::RTYPE_CORE;
      end
      else
      begin
         rst_kind = crsi_pkg::RTYPE_NONE;
      end
   end

   // handshakes complete while ready is registered high and valid is held
   assign wr_go = st_q.awready & st_q.wready & s_axi_awvalid & s_axi_wvalid;
   assign rd_go = st_q.arready & s_axi_arvalid;
   assign wmask = {{8{s_axi_wstrb[3]}}, {8{s_axi_wstrb[2]}}, {8{s_axi_wstrb[1]}}, {8{s_axi_wstrb[0]}}};
   assign wbits = s_axi_wdata & wmask;

   // write address decode
   always_comb
   begin
      case (s_axi_awaddr)
         crsi_pkg::OFF_DBG_ST, crsi_pkg::OFF_SYNDROME, crsi_pkg::OFF_MCHK_ST, crsi_pkg::OFF_MSTATE,
         crsi_pkg::OFF_VERSION, crsi_pkg::OFF_PC, crsi_pkg::OFF_IRQ_ST, crsi_pkg::OFF_IRQ_MK:
            wr_hit = 1'b1;
         default:
            wr_hit = 1'b0;
      endcase
   end

   // read mux; version is read live from the core inputs, never stored
   always_comb
   begin
      rd_hit = 1'b1;
      case (s_axi_araddr)
         crsi_pkg::OFF_DBG_ST:   rd_val = st_q.dbg_st;
         crsi_pkg::OFF_SYNDROME: rd_val = st_q.syndrome;
         crsi_pkg::OFF_MCHK_ST:  rd_val = st_q.mchk_st;
         crsi_pkg::OFF_MSTATE:   rd_val = st_q.mstate;
         crsi_pkg::OFF_VERSION:  rd_val = {owner_field, version_number_field};
         crsi_pkg::OFF_PC:     rd_val = st_q.pc;
         crsi_pkg::OFF_IRQ_ST: rd_val = {30'h0000_0000, st_q.irq_st};
         crsi_pkg::OFF_IRQ_MK: rd_val = {30'h0000_0000, st_q.irq_mk};
         default:
         begin
            rd_val = 32'h0000_0000;
            rd_hit = 1'b0;
         end
      endcase
   end

   // ************************************************************
   // next state
   // ************************************************************
   always_comb
   begin
      st_d = st_q;

      // write channel: both address and data must be present before ready rises
      st_d.awready = 1'b0;
      st_d.wready  = 1'b0;
      if (!st_q.awready && !st_q.bvalid && s_axi_awvalid && s_axi_wvalid)
      begin
         st_d.awready = 1'b1;
         st_d.wready  = 1'b1;
      end
      if (st_q.bvalid && s_axi_bready)
      begin
         st_d.bvalid = 1'b0;
      end
      if (wr_go)
      begin
         st_d.bvalid = 1'b1;
         st_d.bresp  = wr_hit ? crsi_pkg::RESP_OKAY : crsi_pkg::RESP_SLVERR;
         case (s_axi_awaddr)
            // software clears the reset type by writing ones
            crsi_pkg::OFF_DBG_ST:   st_d.dbg_st = st_q.dbg_st & ~(wbits & crsi_pkg::DBG_ST_W1C);
            crsi_pkg::OFF_SYNDROME: st_d.syndrome = (st_q.syndrome & ~wmask) | wbits;
            crsi_pkg::OFF_MCHK_ST:  st_d.mchk_st = st_q.mchk_st & ~(wbits & crsi_pkg::MCHK_ST_W1C);
            crsi_pkg::OFF_MSTATE:
               st_d.mstate = (st_q.mstate & ~(wmask & crsi_pkg::MSTATE_WMASK)) | (wbits & crsi_pkg::MSTATE_WMASK);
            crsi_pkg::OFF_PC:
               st_d.pc = (st_q.pc & ~(wmask & crsi_pkg::PC_WMASK)) | (wbits & crsi_pkg::PC_WMASK);
            crsi_pkg::OFF_IRQ_ST: st_d.irq_st = st_q.irq_st & ~wbits[1:0];
            crsi_pkg::OFF_IRQ_MK: st_d.irq_mk = (st_q.irq_mk & ~wmask[1:0]) | wbits[1:0];
            default:              st_d.dbg_st = st_q.dbg_st;
         endcase
      end

      // events are applied after the write so a set beats a same-cycle clear
      st_d.dbg_st[crsi_pkg::DBG_FLAGS-1:0]        = st_d.dbg_st[crsi_pkg::DBG_FLAGS-1:0] | dbg_evt;
      st_d.syndrome[crsi_pkg::SYNC_MCHK_BIT]      = st_d.syndrome[crsi_pkg::SYNC_MCHK_BIT] | sync_mcheck;
      st_d.mchk_st[crsi_pkg::ASYNC_MCHK_BIT]      = st_d.mchk_st[crsi_pkg::ASYNC_MCHK_BIT] | async_mcheck;
      st_d.irq_st = st_d.irq_st | {sync_mcheck | async_mcheck, |dbg_evt};

      // a core, chip or system reset overrides software and events on the fields below for as long as it is held
      // hold reset values
      if (any_rst)
      begin
         st_d.dbg_st[crsi_pkg::DBG_FLAGS-1:0] = '0;
         st_d.dbg_st[crsi_pkg::RTYPE_LSB +: 2] = rst_kind;
         st_d.syndrome[crsi_pkg::SYNC_MCHK_BIT] = 1'b0;
         st_d.mchk_st[crsi_pkg::ASYNC_MCHK_BIT] = 1'b0;
         st_d.mstate = crsi_pkg::MSTATE_RESET;
         st_d.pc = crsi_pkg::PC_RESET;
      end
      st_d.irq = |(st_d.irq_st & st_d.irq_mk);

      // read channel: one read in flight, data registered with the answer
      st_d.arready = 1'b0;
      if (!st_q.arready && !st_q.rvalid && s_axi_arvalid)
      begin
         st_d.arready = 1'b1;
      end
      if (st_q.rvalid && s_axi_rready)
      begin
         st_d.rvalid = 1'b0;
      end
      if (rd_go)
      begin
         st_d.rvalid = 1'b1;
         st_d.rdata  = rd_val;
         st_d.rresp  = rd_hit ? crsi_pkg::RESP_OKAY : crsi_pkg::RESP_SLVERR;
      end
   end

   // state register; srst is the power-on clear and leaves the type at 00
   always_ff @(posedge clk_sys)
   begin
      if (srst)
      begin
         st_q <= crsi_pkg::ST_RESET;
      end
      else
      begin
         st_q <= st_d;
      end
   end

   // ************************************************************
   // outputs, all straight from the state register
   // ************************************************************
   assign s_axi_awready   = st_q.awready;
   assign s_axi_wready    = st_q.wready;
   assign s_axi_bvalid    = st_q.bvalid;
   assign s_axi_bresp     = st_q.bresp;
   assign s_axi_arready   = st_q.arready;
   assign s_axi_rvalid    = st_q.rvalid;
   assign s_axi_rdata     = st_q.rdata;
   assign s_axi_rresp     = st_q.rresp;
   assign machine_state   = st_q.mstate;
   assign program_counter = st_q.pc;
   assign irq             = st_q.irq;

   // ************************************************************
   // checks
   // ************************************************************
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (srst);

   sequence s_rst_held;
      any_rst;
   endsequence

   sequence s_version_read;
      rd_go && (s_axi_araddr == crsi_pkg::OFF_VERSION);
   endsequence

   sequence s_core_only;
      rst_src.core && !rst_src.chip && !rst_src.system;
   endsequence

   sequence s_chip_top;
      rst_src.chip && !rst_src.system;
   endsequence

   chk_debug_flags_clear: assert property (s_rst_held |=> st_q.dbg_st[14:0] == 15'h0000)
      else $error("debug flags not cleared by reset");

   chk_reset_type_kind: assert property (s_rst_held |=> st_q.dbg_st[29:28] == $past(rst_kind))
      else $error("reset type field does not match the reset source");

   // type field only moves on reset or write
   chk_type_field_stable: assert property (!any_rst && !(wr_go && s_axi_awaddr == crsi_pkg::OFF_DBG_ST)
      |=> $stable(st_q.dbg_st[29:28]))
      else $error("reset type field changed without reset or write");

   chk_mcheck_flags_clear: assert property (s_rst_held |=> !st_q.syndrome[27] && !st_q.mchk_st[31])
      else $error("machine check flags not cleared by reset");

   chk_machine_state_zero: assert property (s_rst_held |=> machine_state == 32'h0000_0000)
      else $error("machine state not zero after reset");

   chk_pc_reset_value: assert property (s_rst_held ##1 s_rst_held |-> program_counter == 32'hffff_fffc)
      else $error("program counter not at last word during reset");

   chk_version_read_live: assert property (s_version_read |=> s_axi_rvalid
      && s_axi_rdata == {$past(owner_field), $past(version_number_field)})
      else $error("version read does not follow core inputs");

   chk_event_set_wins: assert property (!any_rst && dbg_evt[0] |=> st_q.dbg_st[0] && st_q.irq_st[0])
      else $error("debug event lost against a clear");

   chk_addr_cmp_clear: assert property (s_rst_held |=> st_q.dbg_st[8:5] == 4'h0)
      else $error("instruction address compare flags not cleared by reset");

   chk_data_cmp_clear: assert property (s_rst_held |=> st_q.dbg_st[12:9] == 4'h0)
      else $error("data compare flags not cleared by reset");

   // async summary cleared even against an event
   chk_async_summary_clear: assert property (s_rst_held |=> !st_q.mchk_st[crsi_pkg::ASYNC_MCHK_BIT])
      else $error("async machine check summary not cleared by reset");

   chk_supervisor_start: assert property (s_rst_held |=> (machine_state & crsi_pkg::MSTATE_WMASK) == 32'h0)
      else $error("machine state control bits not cleared by reset");

   chk_core_type_code: assert property (s_core_only |=> st_q.dbg_st[29:28] == 2'h1)
      else $error("core reset not recorded as core");

   chk_chip_type_code: assert property (s_chip_top |=> st_q.dbg_st[29:28] == 2'h2)
      else $error("chip reset not recorded as chip");

   chk_sys_type_code: assert property (rst_src.system |=> st_q.dbg_st[29:28] == 2'h3)
      else $error("system reset not recorded as system");

   // values held through a long reset
   chk_reset_hold_state: assert property (s_rst_held ##1 s_rst_held |-> machine_state == 32'h0)
      else $error("machine state moved while reset held");

   // unmapped writes and reads answer with an error
   chk_write_unmapped: assert property (wr_go && !wr_hit |=> s_axi_bresp == crsi_pkg::RESP_SLVERR)
      else $error("unmapped write not answered with an error");

   chk_read_unmapped: assert property (rd_go && !rd_hit |=> s_axi_rresp == crsi_pkg::RESP_SLVERR)
      else $error("unmapped read not answered with an error");

   // check events set their flags outside reset
   chk_sync_set_wins: assert property (!any_rst && sync_mcheck |=> st_q.syndrome[27])
      else $error("sync machine check event lost");

   chk_async_set_wins: assert property (!any_rst && async_mcheck |=> st_q.mchk_st[31] && st_q.irq_st[1])
      else $error("async machine check event lost");

   chk_write_answer: assert property (wr_go |=> s_axi_bvalid ##0 !s_axi_awready[*2])
      else $error("write not answered in one cycle");

endmodule // crsi_top

`default_nettype wire

// File: crsi_sysmodel.sv
// system-side model: reset sources and version inputs of the core reset block
// assumes the bench asks for resets on req_src, one clock clk_sys
`timescale 1ns/1ps
`default_nettype none

module crsi_sysmodel (
   input  wire logic                [2:0]  req_src,
   input  wire logic                       clk_sys,
   input  wire logic                [31:0] id_val,
   output var  crsi_pkg::crsi_rst_src_s    rst_src,
   output logic                     [11:0] owner_field,
   output logic                     [19:0] version_number_field
);
   // ************************************************************
   // reset sources
   // ************************************************************
   // sources move only after an edge, like synchronous system logic
   always_ff @(posedge clk_sys)
   begin
      rst_src <= crsi_pkg::crsi_rst_src_s'(req_src);
   end

   // version inputs
   // taken straight from id_val with no register, so they change whenever the bench changes id_val
   assign owner_field          = id_val[31:20];
   assign version_number_field = id_val[19:0];
endmodule // crsi_sysmodel
`default_nettype wire

// File: crsi_bench.sv
// self-checking bench of the core reset state block against a register model
// assumes crsi_pkg, crsi_top and crsi_sysmodel are compiled first
`timescale 1ns/1ps
`default_nettype none

module crsi_bench;
   logic                    clk_sys = 1'b0;
   logic                    srst = 1'b1;
   logic [2:0]              req_src = 3'h0;
   logic [31:0]             id_val = 32'h0;
   crsi_pkg::crsi_rst_src_s rst_src;
   logic [14:0]             dbg_evt = 15'h0;
   logic                    sync_mcheck = 1'b0, async_mcheck = 1'b0;
   logic [11:0]             owner_field;
   logic [19:0]             version_number_field;
   logic [7:0]              s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
   logic [31:0]             s_axi_wdata = 32'h0;
   logic [3:0]              s_axi_wstrb = 4'hf;
   logic                    s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic                    s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic                    s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
   logic [1:0]              s_axi_bresp, s_axi_rresp, rs;
   logic [31:0]             s_axi_rdata, machine_state, program_counter, rd, w;
   int                      n_mismatch = 0, comparisons = 0, k;
   int                      m_dbg, m_syn, m_mchk, m_mst, m_pc, m_ist, m_imk;
   logic [2:0]              srcs [4] = '{3'h4, 3'h2, 3'h1, 3'h6};
   int                      typ [4] = '{1, 2, 3, 2};

   crsi_sysmodel crsi_sysmodel_i (.req_src, .clk_sys, .id_val, .rst_src, .owner_field, .version_number_field);
   crsi_top crsi_top_i (.clk_sys, .srst, .rst_src, .dbg_evt, .sync_mcheck, .async_mcheck, .owner_field,
      .version_number_field, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
      .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
      .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
      .machine_state, .program_counter, .irq);

   // 50 MHz clock
   always #10 clk_sys = ~clk_sys;

   // ************************************************************
   // checking and closing
   // ************************************************************
   task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // responses and the interrupt line, as small codes
   task automatic chk_code(input logic [1:0] got, input logic [1:0] exp);
      comparisons++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic wrap_up();
      $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
      if (n_mismatch == 0 && comparisons > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   // ************************************************************
   // bus master, entered just after a rising edge
   // ************************************************************
   // outputs are read before the edge's own updates land, so no race
   task automatic axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      int n;
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      // the answer of a previous call still shows in this step, so wait an edge first
      for (n = 0; n < 40; n++)
      begin
         @(posedge clk_sys);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid) break;
      end
      r = s_axi_bresp;
      if (n == 40) begin n_mismatch++; wrap_up(); end
   endtask

   task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      int n;
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      for (n = 0; n < 40; n++)
      begin
         @(posedge clk_sys);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid) break;
      end
      d = s_axi_rdata;
      r = s_axi_rresp;
      if (n == 40) begin n_mismatch++; wrap_up(); end
   endtask

   task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
      axr(a, rd, rs);
      chk_code(rs, crsi_pkg::RESP_OKAY);
      chk_word(rd, exp);
   endtask

   // ************************************************************
   // model of the registers
   // ************************************************************
   // a core, chip or system reset keeps esr apart from its check bit
   function automatic void mreset(input int t);
      m_dbg = t << 28;
      m_syn = m_syn & 32'hf7ff_ffff;
      m_mchk = 32'h0;
      m_mst = 32'h0;
      m_pc = 32'hffff_fffc;
   endfunction

   task automatic evt(input logic [14:0] b, input logic s, input logic a);
      dbg_evt <= b;
      sync_mcheck <= s;
      async_mcheck <= a;
      @(posedge clk_sys);
      dbg_evt <= 15'h0;
      sync_mcheck <= 1'b0;
      async_mcheck <= 1'b0;
      m_dbg |= b;
      if (s) m_syn |= 32'h0800_0000;
      if (a) m_mchk |= 32'h8000_0000;
      m_ist |= {s | a, |b};
   endtask

   task automatic check_all();
      rd_chk(crsi_pkg::OFF_DBG_ST, m_dbg);
      rd_chk(crsi_pkg::OFF_SYNDROME, m_syn);
      rd_chk(crsi_pkg::OFF_MCHK_ST, m_mchk);
      rd_chk(crsi_pkg::OFF_MSTATE, m_mst);
      rd_chk(crsi_pkg::OFF_VERSION, id_val);
      rd_chk(crsi_pkg::OFF_PC, m_pc);
      chk_word(machine_state, m_mst);
      chk_word(program_counter, m_pc);
   endtask

   // ************************************************************
   // main sequence
   // ************************************************************
   initial
   begin
      void'($urandom(41538));
      id_val = $urandom();
      m_syn = 32'h0;
      mreset(0);
      m_ist = 32'h0;
      m_imk = 32'h0;
      repeat (4) @(posedge clk_sys);
      srst <= 1'b0;
      @(posedge clk_sys);
      check_all();
      chk_code({1'b0, irq}, 2'h0);
      // dirty every field, then end each kind of reset; events inside reset must lose
      for (k = 0; k < 4; k++)
      begin
         evt(15'h3fff & 15'($urandom()), 1'b1, 1'b1);
         w = $urandom();
         axw(crsi_pkg::OFF_MSTATE, w, rs);
         m_mst = w & crsi_pkg::MSTATE_WMASK;
         w = $urandom();
         axw(crsi_pkg::OFF_PC, w, rs);
         m_pc = w & crsi_pkg::PC_WMASK;
         check_all();
         req_src <= srcs[k];
         dbg_evt <= 15'h7fff;
         repeat (3) @(posedge clk_sys);
         chk_word(program_counter, crsi_pkg::PC_RESET);
         chk_word(machine_state, 32'h0);
         req_src <= 3'h0;
         dbg_evt <= 15'h0;
         @(posedge clk_sys);
         mreset(typ[k]);
         check_all();
         axw(crsi_pkg::OFF_DBG_ST, 32'h3000_0000, rs);
         m_dbg = 0;
         rd_chk(crsi_pkg::OFF_DBG_ST, 32'h0);
      end
      // unmapped place and the read-only version register
      axw(8'h20, $urandom(), rs);
      chk_code(rs, crsi_pkg::RESP_SLVERR);
      axr(8'h20, rd, rs);
      chk_code(rs, crsi_pkg::RESP_SLVERR);
      chk_word(rd, 32'h0);
      id_val <= $urandom();
      axw(crsi_pkg::OFF_VERSION, 32'h0, rs);
      rd_chk(crsi_pkg::OFF_VERSION, id_val);
      // interrupt: raise while masked, unmask, clear
      srst <= 1'b1;
      @(posedge clk_sys);
      srst <= 1'b0;
      @(posedge clk_sys);
      axw(crsi_pkg::OFF_IRQ_MK, 32'h0, rs);
      evt(15'h1, 1'b0, 1'b1);
      repeat (2) @(posedge clk_sys);
      chk_code({1'b0, irq}, 2'h0);
      rd_chk(crsi_pkg::OFF_IRQ_ST, 32'h3);
      axw(crsi_pkg::OFF_IRQ_MK, 32'h1, rs);
      repeat (2) @(posedge clk_sys);
      chk_code({1'b0, irq}, 2'h1);
      axw(crsi_pkg::OFF_IRQ_ST, 32'h1, rs);
      repeat (2) @(posedge clk_sys);
      chk_code({1'b0, irq}, 2'h0);
      rd_chk(crsi_pkg::OFF_IRQ_ST, 32'h2);
      axw(crsi_pkg::OFF_MCHK_ST, 32'h8000_0000, rs);
      rd_chk(crsi_pkg::OFF_MCHK_ST, 32'h0);
      wrap_up();
   end
endmodule // crsi_bench
`default_nettype wire
